//--- hdl/adc_out_cfg.svh
// Purpose: offsets, field positions, reset values and codes for the output configuration bank
// Assumes: byte addresses on a 32-bit AXI4-Lite bus, one register per aligned word
// Notes:   printed offsets are not all multiples of four, so each is an index; address is index times four
`ifndef ADC_OUT_CFG_SVH
`define ADC_OUT_CFG_SVH

`define IDX_INTERFACE_SELECT   8'h41
`define IDX_CLOCK_PLACEMENT    8'h44
`define IDX_NUMBER_FORMAT      8'h50
`define IDX_PATTERN_LOWER      8'h51
`define IDX_PATTERN_UPPER      8'h52
`define IDX_BIAS_CANCEL        8'h53

`define IFSEL_MSB              7
`define IFSEL_LSB              6
`define RISE_MSB               7
`define RISE_LSB               5
`define FALL_MSB               4
`define FALL_LSB               2
`define FMT_MSB                2
`define FMT_LSB                1
`define PAT_UPPER_MSB          5
`define BIAS_BIT               6

`define CODE_PIN               2'h0
`define CODE_FIRST             2'h2
`define CODE_SECOND            2'h3

`define REG_RESET              8'h00
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2

`endif

//--- hdl/adc_out_pkg.sv
// Purpose: types shared by the output configuration bank
// Assumes: nothing beyond the cfg header
// Notes:   edge placement is given in twenty-sixths of a sample period
package adc_out_pkg;
    typedef enum logic [1:0] {
        IF_LVDS = 2'b00,
        IF_CMOS = 2'b01
    } out_if_t;

    typedef enum logic [2:0] {
        EDGE_DEFAULT   = 3'b000,
        EDGE_LATE_4    = 3'b001,
        EDGE_LATE_6    = 3'b010,
        EDGE_ON_DATA   = 3'b011,
        EDGE_EARLY_4   = 3'b100,
        EDGE_UNDEFINED = 3'b111
    } edge_place_t;

    typedef enum logic [1:0] {
        FMT_TWOS   = 2'b00,
        FMT_OFFSET = 2'b01
    } num_fmt_t;
endpackage

//--- hdl/adc_out_config_regs.sv
// Purpose: output section configuration bank reached over AXI4-Lite
// Assumes: format_select_pin is asynchronous to clk; host writes zero to undefined bits
// Notes:   decoded settings are registered outputs, one cycle after the register changes
//
// Overview of operation
// - Rising placement in bits 7-5; 000,100 default
// - Falling placement in bits 4-2; 000,100 default
// - LVDS rising: 101 late, 110 on data, 111 early
// - CMOS rising: 101 late 4, 110 late 6, 111 on data
// - CMOS falling code 101 delays edge four twenty-sixths
// - Format field: 00 pin, 10 twos, 11 offset
// - Register 0x51 holds pattern low eight bits
// - Register 0x52 bits 5-0 hold pattern upper six
// - Register 0x53 bit 6 enables offset correction
// - Interface field: 00 pin, 10 LVDS, 11 CMOS
//
// Design decision made here: register access over AXI4-Lite.
`include "adc_out_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_out_config_regs
    import adc_out_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // AXI4-Lite write address and data
    input  wire logic [9:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [9:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Device pin
    input  wire logic        format_select_pin,
    // Decoded settings
    output var  out_if_t     out_interface,
    output var  edge_place_t rise_placement,
    output var  edge_place_t fall_placement,
    output var  num_fmt_t    number_format,
    output var  logic [13:0] user_pattern,
    output var  logic        bias_cancel_enable
);

    logic [7:0] interface_select;
    logic [7:0] output_clock_edge_placement;
    logic [7:0] sample_number_format;
    logic [7:0] user_pattern_lower;
    logic [7:0] user_pattern_upper;
    logic [7:0] dc_bias_cancel_control;
    logic       pin_meta;
    logic       pin_sync;
    logic [9:0] aw_addr;
    logic       aw_held;
    logic [7:0] w_data;
    logic       w_lane0;
    logic       w_held;

    // Two-flop synchroniser on the strap pin
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= format_select_pin;
            pin_sync <= pin_meta;
        end
    end

    // Index from a byte address; misaligned gives none
    function automatic logic [8:0] reg_index(input logic [9:0] addr);
        if (addr[1:0] != 2'b00) begin
            reg_index = 9'h100;
        end else begin
            reg_index = {1'b0, addr[9:2]};
        end
    endfunction

    function automatic logic is_mapped(input logic [8:0] idx);
        is_mapped = (idx == {1'b0, `IDX_INTERFACE_SELECT}) || (idx == {1'b0, `IDX_CLOCK_PLACEMENT})
                 || (idx == {1'b0, `IDX_NUMBER_FORMAT}) || (idx == {1'b0, `IDX_PATTERN_LOWER})
                 || (idx == {1'b0, `IDX_PATTERN_UPPER}) || (idx == {1'b0, `IDX_BIAS_CANCEL});
    endfunction

    // Address and data may arrive in either order; each is held until both are in
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_held <= 1'b0;
            aw_addr <= 10'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (aw_held && w_held) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            w_held  <= 1'b0;
            w_data  <= 8'h00;
            w_lane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_data  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
        end else if (aw_held && w_held) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    // Write response; unmapped address answers SLVERR and stores nothing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (aw_held && w_held) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(reg_index(aw_addr)) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register store, one process per register; undefined bits are kept as written and read back
    logic       store_go;
    logic [8:0] store_idx;
    assign store_go  = aw_held && w_held && w_lane0;
    assign store_idx = reg_index(aw_addr);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            interface_select <= `REG_RESET;
        end else if (store_go && store_idx == {1'b0, `IDX_INTERFACE_SELECT}) begin
            interface_select <= w_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            output_clock_edge_placement <= `REG_RESET;
        end else if (store_go && store_idx == {1'b0, `IDX_CLOCK_PLACEMENT}) begin
            output_clock_edge_placement <= w_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sample_number_format <= `REG_RESET;
        end else if (store_go && store_idx == {1'b0, `IDX_NUMBER_FORMAT}) begin
            sample_number_format <= w_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            user_pattern_lower <= `REG_RESET;
        end else if (store_go && store_idx == {1'b0, `IDX_PATTERN_LOWER}) begin
            user_pattern_lower <= w_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            user_pattern_upper <= `REG_RESET;
        end else if (store_go && store_idx == {1'b0, `IDX_PATTERN_UPPER}) begin
            user_pattern_upper <= w_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dc_bias_cancel_control <= `REG_RESET;
        end else if (store_go && store_idx == {1'b0, `IDX_BIAS_CANCEL}) begin
            dc_bias_cancel_control <= w_data;
        end
    end

    // Read channel: one read at a time, answered one cycle after the address is taken
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            if (reg_index(s_axi_araddr) == {1'b0, `IDX_INTERFACE_SELECT}) begin
                s_axi_rdata <= {24'h000000, interface_select};
            end else if (reg_index(s_axi_araddr) == {1'b0, `IDX_CLOCK_PLACEMENT}) begin
                s_axi_rdata <= {24'h000000, output_clock_edge_placement};
            end else if (reg_index(s_axi_araddr) == {1'b0, `IDX_NUMBER_FORMAT}) begin
                s_axi_rdata <= {24'h000000, sample_number_format};
            end else if (reg_index(s_axi_araddr) == {1'b0, `IDX_PATTERN_LOWER}) begin
                s_axi_rdata <= {24'h000000, user_pattern_lower};
            end else if (reg_index(s_axi_araddr) == {1'b0, `IDX_PATTERN_UPPER}) begin
                s_axi_rdata <= {24'h000000, user_pattern_upper};
            end else if (reg_index(s_axi_araddr) == {1'b0, `IDX_BIAS_CANCEL}) begin
                s_axi_rdata <= {24'h000000, dc_bias_cancel_control};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Shared decode of the two-bit pin/first/second selectors
    function automatic logic pick_second(input logic [1:0] code, input logic pin);
        if (code == `CODE_SECOND) begin
            pick_second = 1'b1;
        end else if (code == `CODE_FIRST) begin
            pick_second = 1'b0;
        end else begin
            pick_second = pin;
        end
    endfunction

    // Strap pin high picks CMOS and offset binary; code 01 is undefined and falls back to the pin
    logic cmos_mode;
    assign cmos_mode = pick_second(interface_select[`IFSEL_MSB:`IFSEL_LSB], pin_sync);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_interface <= IF_LVDS;
            number_format <= FMT_TWOS;
        end else begin
            out_interface <= cmos_mode ? IF_CMOS : IF_LVDS;
            number_format <= pick_second(sample_number_format[`FMT_MSB:`FMT_LSB], pin_sync)
                             ? FMT_OFFSET : FMT_TWOS;
        end
    end

    // Rising placement; codes 001-011 are undefined and reported as such
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rise_placement <= EDGE_DEFAULT;
        end else begin
            case (output_clock_edge_placement[`RISE_MSB:`RISE_LSB])
                3'h0, 3'h4: rise_placement <= EDGE_DEFAULT;
                3'h5:       rise_placement <= EDGE_LATE_4;
                3'h6:       rise_placement <= cmos_mode ? EDGE_LATE_6 : EDGE_ON_DATA;
                3'h7:       rise_placement <= cmos_mode ? EDGE_ON_DATA : EDGE_EARLY_4;
                default:    rise_placement <= EDGE_UNDEFINED;
            endcase
        end
    end

    // Falling placement; beyond 101 in CMOS nothing is defined here
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fall_placement <= EDGE_DEFAULT;
        end else begin
            case (output_clock_edge_placement[`FALL_MSB:`FALL_LSB])
                3'h0, 3'h4: fall_placement <= EDGE_DEFAULT;
                3'h5:       fall_placement <= cmos_mode ? EDGE_LATE_4 : EDGE_UNDEFINED;
                default:    fall_placement <= EDGE_UNDEFINED;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            user_pattern       <= 14'h0000;
            bias_cancel_enable <= 1'b0;
        end else begin
            user_pattern       <= {user_pattern_upper[`PAT_UPPER_MSB:0], user_pattern_lower};
            bias_cancel_enable <= dc_bias_cancel_control[`BIAS_BIT];
        end
    end

endmodule

`default_nettype wire

//--- tb/adc_out_config_regs_monitor.sv
// Purpose: checker on the ports of the configuration bank
// Assumes: one clock domain
// Notes:   decoded outputs may change only after a write or a pin change
`timescale 1ns/1ps
`default_nettype none
module adc_out_config_regs_monitor
    import adc_out_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // Watched ports
    input wire logic        s_axi_bvalid,
    input wire logic        format_select_pin,
    input wire out_if_t     out_interface,
    input wire edge_place_t rise_placement,
    input wire edge_place_t fall_placement,
    input wire num_fmt_t    number_format,
    input wire logic [13:0] user_pattern,
    input wire logic        bias_cancel_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_rise_lvds; out_interface == IF_LVDS |-> rise_placement != EDGE_LATE_6; endproperty
    a_rise_lvds: assert property (p_rise_lvds) else $error("late rise in LVDS");
    property p_rise_cmos; out_interface == IF_CMOS |-> rise_placement != EDGE_EARLY_4; endproperty
    a_rise_cmos: assert property (p_rise_cmos) else $error("early rise in CMOS");
    property p_fall_lvds; out_interface == IF_LVDS |-> fall_placement inside {EDGE_DEFAULT, EDGE_UNDEFINED}; endproperty
    a_fall_lvds: assert property (p_fall_lvds) else $error("bad fall in LVDS");
    property p_fall_cmos; out_interface == IF_CMOS |-> fall_placement inside {EDGE_DEFAULT, EDGE_LATE_4, EDGE_UNDEFINED}; endproperty
    a_fall_cmos: assert property (p_fall_cmos) else $error("bad fall in CMOS");
    // Pattern and bias outputs change only a cycle after the write answer rises
    property p_low_hold; $changed(user_pattern[7:0]) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2); endproperty
    a_low_hold: assert property (p_low_hold) else $error("pattern low moved");
    property p_up_hold; $changed(user_pattern[13:8]) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2); endproperty
    a_up_hold: assert property (p_up_hold) else $error("pattern upper moved");
    property p_bias_hold; $changed(bias_cancel_enable) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2); endproperty
    a_bias_hold: assert property (p_bias_hold) else $error("bias enable moved");
    // Five quiet cycles cover the pin synchroniser and the decode stage
    property p_steady; (!s_axi_bvalid && $stable(format_select_pin)) [*5] |=> $stable(number_format) && $stable(out_interface); endproperty
    a_steady: assert property (p_steady) else $error("mode or format moved");
endmodule
`default_nettype wire

//--- tb/axil_host_model.sv
// Purpose: AXI4-Lite host programming the configuration bank
// Assumes: tasks are entered just after a rising edge
// Notes:   bready and rready stay high, which the bus allows
`timescale 1ns/1ps
`default_nettype none
module axil_host_model (
    // Clock
    input  wire logic        clk,
    // Write side
    output var  logic [9:0]  s_axi_awaddr,
    output var  logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output var  logic [31:0] s_axi_wdata,
    output var  logic [3:0]  s_axi_wstrb,
    output var  logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output var  logic        s_axi_bready,
    // Read side
    output var  logic [9:0]  s_axi_araddr,
    output var  logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output var  logic        s_axi_rready,
    // Wait ran out
    output var  logic        hang
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_araddr, s_axi_arvalid, hang} = '0;
        s_axi_bready = 1'h1;
        s_axi_rready = 1'h1;
    end
    task automatic wr(input logic [9:0] a, input logic [7:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid && n < 100);
        hang <= hang | !s_axi_bvalid;
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid && n < 100);
        hang <= hang | !s_axi_rvalid;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
endmodule
`default_nettype wire

//--- tb/tb_adc_out_config_regs.sv
// Purpose: self-checking bench for the configuration bank
// Assumes: the pin is driven here, the bus by the host model
// Notes:   the placement sweep sets every interface selector code and every rise and fall field code
`include "adc_out_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_adc_out_config_regs
    import adc_out_pkg::*;
;
    logic        clk, arst_n, format_select_pin, hang, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, bias_cancel_enable;
    logic [9:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, v, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    out_if_t     out_interface;
    edge_place_t rise_placement, fall_placement;
    num_fmt_t    number_format;
    logic [13:0] user_pattern;
    int          num_errors, num_checks, k;
    logic [7:0]  idx [6] = '{`IDX_INTERFACE_SELECT, `IDX_CLOCK_PLACEMENT, `IDX_NUMBER_FORMAT,
                             `IDX_PATTERN_LOWER, `IDX_PATTERN_UPPER, `IDX_BIAS_CANCEL};
    adc_out_config_regs u_adc_out_config_regs (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .format_select_pin, .out_interface, .rise_placement, .fall_placement, .number_format, .user_pattern,
        .bias_cancel_enable);
    axil_host_model u_axil_host_model (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hang);
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic out_if_t mode(input logic [1:0] s, input logic pn);
        if (s == `CODE_FIRST) return IF_LVDS;
        if (s == `CODE_SECOND) return IF_CMOS;
        return pn ? IF_CMOS : IF_LVDS;
    endfunction
    function automatic edge_place_t rise(input logic [2:0] c, input logic cm);
        case (c)
            3'h0, 3'h4: return EDGE_DEFAULT;
            3'h5: return EDGE_LATE_4;
            3'h6: return cm ? EDGE_LATE_6 : EDGE_ON_DATA;
            3'h7: return cm ? EDGE_ON_DATA : EDGE_EARLY_4;
            default: return EDGE_UNDEFINED;
        endcase
    endfunction
    function automatic edge_place_t fall(input logic [2:0] c, input logic cm);
        if (c == 3'h0 || c == 3'h4) return EDGE_DEFAULT;
        return (c == 3'h5 && cm) ? EDGE_LATE_4 : EDGE_UNDEFINED;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        if (num_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (hang === 1'h1) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        {arst_n, format_select_pin, num_errors, num_checks} = '0;
        seed = 32'h13BC6646;
        repeat (10) @(posedge clk);
        arst_n <= 1'h1;
        repeat (2) @(posedge clk);
        for (k = 0; k < 6; k++) begin
            u_axil_host_model.rd({idx[k], 2'h0}, d, r);
            chk("reset value", `REG_RESET, d);
        end
        // Every selector code against every rise and fall code, pin at random
        for (k = 0; k < 256; k++) begin
            v = rnd();
            format_select_pin <= v[0];
            u_axil_host_model.wr({idx[0], 2'h0}, {k[1:0], 6'h00}, r);
            u_axil_host_model.wr({idx[1], 2'h0}, {k[7:2], 2'h0}, r);
            repeat (4) @(posedge clk);
            chk("interface", mode(k[1:0], v[0]), out_interface);
            chk("rise", rise(k[7:5], mode(k[1:0], v[0]) == IF_CMOS), rise_placement);
            chk("fall", fall(k[4:2], mode(k[1:0], v[0]) == IF_CMOS), fall_placement);
        end
        for (k = 0; k < 8; k++) begin
            format_select_pin <= k[2];
            u_axil_host_model.wr({idx[2], 2'h0}, {5'h00, k[1:0], 1'h0}, r);
            repeat (4) @(posedge clk);
            chk("format", (k[1:0] == 2'h3 || (!k[1] && k[2])) ? FMT_OFFSET : FMT_TWOS, number_format);
        end
        for (k = 0; k < 16; k++) begin
            v = (k == 0) ? 32'h00007FFF : rnd();
            u_axil_host_model.wr({idx[3], 2'h0}, v[7:0], r);
            chk("write resp", `RESP_OKAY, r);
            u_axil_host_model.wr({idx[4], 2'h0}, {2'h0, v[13:8]}, r);
            u_axil_host_model.wr({idx[5], 2'h0}, {1'h0, v[14], 6'h00}, r);
            repeat (2) @(posedge clk);
            chk("pattern", v[13:0], user_pattern);
            chk("bias enable", v[14], bias_cancel_enable);
            u_axil_host_model.rd({idx[4], 2'h0}, d, r);
            chk("upper readback", v[13:8], d);
        end
        u_axil_host_model.wr(10'h3FC, 8'hA5, r);
        chk("unmapped write", `RESP_SLVERR, r);
        u_axil_host_model.rd(10'h3FC, d, r);
        chk("unmapped read", `RESP_SLVERR, r);
        chk("unmapped data", 32'h0, d);
        summarize();
    end
endmodule
bind adc_out_config_regs adc_out_config_regs_monitor u_adc_out_config_regs_monitor (.clk, .arst_n, .s_axi_bvalid,
    .format_select_pin, .out_interface, .rise_placement, .fall_placement, .number_format, .user_pattern,
    .bias_cancel_enable);
`default_nettype wire
